//--- rtl/sms_pkg.sv
/*
  Shared constants, states and carrier types of the serial peripheral port.
  Assumes a single 100 MHz peripheral clock; no software-visible registers.
*/
`default_nettype none
package sms_pkg;
  // ==========================================================================
  // Widths and counts
  localparam int unsigned SMS_BYTE_W = 8;
  localparam int unsigned SMS_HALF_W = 10;
  localparam int unsigned SMS_HALF_MAX = 1024;
  localparam int unsigned SMS_EDGES_PER_BYTE = 16;
  localparam int unsigned SMS_CLK_PERIOD_NS = 10;
  localparam logic [3:0] SMS_EDGE_LAST = 4'hF;
  localparam logic [2:0] SMS_BIT_LAST = 3'h7;
  localparam logic [7:0] SMS_IDLE_FILL = 8'hFF;
  localparam logic [9:0] SMS_HALF_RST = 10'h000;

  // ==========================================================================
  // Master sequence, Gray coded along idle-lead-transfer-lag
  typedef enum logic [1:0] {
    SMS_ST_IDLE = 2'h0,
    SMS_ST_LEAD = 2'h1,
    SMS_ST_XFER = 2'h3,
    SMS_ST_LAG = 2'h2
  } sms_state_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic master;
    logic cpol;
    logic cpha;
    logic lsb_first_select;
    logic [SMS_HALF_W-1:0] half_m1;
  } sms_cfg_s;

  typedef struct packed {
    sms_state_e state;
    logic shift_clock;
    logic select_n;
    logic sclk_prev;
    logic sel_prev_n;
    logic [SMS_BYTE_W-1:0] tx_sh;
    logic [SMS_BYTE_W-1:0] rx_sh;
    logic [2:0] bits;
    logic [3:0] edges;
    logic skip;
    logic reload;
    logic rx_valid;
    logic [SMS_BYTE_W-1:0] rx_data;
    logic miso_oe;
  } sms_q_s;

  function automatic logic sms_out_bit(input logic [SMS_BYTE_W-1:0] sh, input logic lsb);
    sms_out_bit = lsb ? sh[0] : sh[SMS_BYTE_W-1];
  endfunction : sms_out_bit

  function automatic logic [SMS_BYTE_W-1:0] sms_shift(input logic [SMS_BYTE_W-1:0] sh, input logic lsb,
                                                       input logic din);
    sms_shift = lsb ? {din, sh[SMS_BYTE_W-1:1]} : {sh[SMS_BYTE_W-2:0], din};
  endfunction : sms_shift
endpackage : sms_pkg
`default_nettype wire

//--- rtl/sms_half_tick.sv
/*
  Half-period tick generator for the master shift clock.
  Assumes i_half_m1 is stable during a frame; restart holds the count at zero.
*/
`default_nettype none
module sms_half_tick
  import sms_pkg::*;
#(
  parameter int unsigned HALF_W = SMS_HALF_W
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_restart,
  input wire logic [HALF_W-1:0] i_half_m1,
  output logic o_tick
);
  // ==========================================================================
  // Elaboration check
  generate
    if (HALF_W < 1 || HALF_W > SMS_HALF_W) begin : g_bad_width
      $error("sms_half_tick: HALF_W out of range");
    end
  endgenerate

  // ==========================================================================
  // Counter
  logic [HALF_W-1:0] cnt_ff;
  logic [HALF_W-1:0] nxt_cnt;

  assign o_tick = i_ce && !i_restart && (cnt_ff == i_half_m1);

  always_comb begin
    if (i_restart || o_tick) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + HALF_W'(1);
    end
  end

  // Half phase never exceeds 2**HALF_W cycles
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : sms_half_tick
`default_nettype wire

//--- rtl/sms_port.sv
/*
  Serial peripheral port, master or slave, one byte per handshake.
  Assumes all pin inputs are synchronous to i_clock; pads resolve the enables.
*/
// Notes on behaviour
// - The port runs either as master driving shift clock and select, or as slave of an external master.
// - As master the shift clock is the peripheral clock divided by 2 up to 2048.
// - As master, select leads the first edge and lags the last edge by at least half a clock period.
// - As master, each clock phase lasts at most 1024 peripheral clocks.
// - As slave, MISO is released while deselected and driven within one clock after select asserts.
// - As slave, MISO is released within one clock after select deasserts.
// - Bit order is MSB first when lsb_first_select is low and LSB first when it is high.
// - Both clock-phase settings are supported, data changing on trailing edges or on leading edges after the first.
`default_nettype none
module sms_port
  import sms_pkg::*;
#(
  parameter int unsigned HALF_W = SMS_HALF_W
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire sms_cfg_s i_cfg,
  input wire logic i_tx_valid,
  input wire logic [SMS_BYTE_W-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [SMS_BYTE_W-1:0] o_rx_data,
  output logic o_busy,
  input wire logic i_shift_clock,
  output logic o_shift_clock,
  output logic o_shift_clock_oe,
  input wire logic i_select_n,
  output logic o_select_n,
  output logic o_select_n_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe
);
  // ==========================================================================
  // Elaboration check
  generate
    if (HALF_W != SMS_HALF_W) begin : g_bad_width
      $error("sms_port: HALF_W must match the 1024-cycle phase limit");
    end
  endgenerate

  // ==========================================================================
  // State and divider
  sms_q_s q_ff;
  sms_q_s nxt_q;
  logic tick;
  logic master;
  logic idle;

  assign master = i_cfg.master;
  assign idle = (q_ff.state == SMS_ST_IDLE);

  sms_half_tick #(
    .HALF_W(HALF_W)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_restart(idle || !master),
    .i_half_m1(i_cfg.half_m1),
    .o_tick(tick)
  );

  // ==========================================================================
  // Edge decode
  logic sel_act;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic frame_start;
  logic load_now;
  logic din;
  logic [SMS_BYTE_W-1:0] rx_next;

  always_comb begin
    sel_act = !i_select_n;
    if (master) begin
      lead_edge = tick && (q_ff.state == SMS_ST_XFER) && !q_ff.edges[0];
      trail_edge = tick && (q_ff.state == SMS_ST_XFER) && q_ff.edges[0];
      frame_start = idle && i_tx_valid && i_ce;
      din = i_miso;
    end else begin
      // Slave edges rely on the master's slow clock and select spacing
      lead_edge = sel_act && (q_ff.sclk_prev == i_cfg.cpol) && (i_shift_clock != i_cfg.cpol);
      trail_edge = sel_act && (q_ff.sclk_prev != i_cfg.cpol) && (i_shift_clock == i_cfg.cpol);
      frame_start = q_ff.sel_prev_n && sel_act;
      din = i_mosi;
    end
    sample_edge = i_cfg.cpha ? trail_edge : lead_edge;
    shift_edge = i_cfg.cpha ? lead_edge : trail_edge;
    load_now = frame_start || (shift_edge && q_ff.reload);
    rx_next = sms_shift(q_ff.rx_sh, i_cfg.lsb_first_select, din);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.rx_valid = 1'b0;
    nxt_q.sclk_prev = i_shift_clock;
    nxt_q.sel_prev_n = i_select_n;
    nxt_q.miso_oe = !master && sel_act;

    if (load_now) begin
      nxt_q.tx_sh = i_tx_valid ? i_tx_data : SMS_IDLE_FILL;
      nxt_q.reload = 1'b0;
      // With CPHA 1 the first bit is already on the line at the first edge
      nxt_q.skip = i_cfg.cpha && frame_start;
      if (frame_start) begin
        nxt_q.bits = '0;
      end
    end else if (shift_edge) begin
      if (q_ff.skip) begin
        nxt_q.skip = 1'b0;
      end else begin
        nxt_q.tx_sh = sms_shift(q_ff.tx_sh, i_cfg.lsb_first_select, 1'b0);
      end
    end

    if (sample_edge) begin
      nxt_q.rx_sh = rx_next;
      nxt_q.bits = q_ff.bits + 3'h1;
      if (q_ff.bits == SMS_BIT_LAST) begin
        nxt_q.rx_data = rx_next;
        nxt_q.rx_valid = 1'b1;
        nxt_q.reload = 1'b1;
      end
    end

    if (!master && !sel_act) begin
      nxt_q.bits = '0;
      nxt_q.reload = 1'b0;
      nxt_q.skip = 1'b0;
    end

    case (q_ff.state)
      SMS_ST_IDLE: begin
        nxt_q.shift_clock = i_cfg.cpol;
        nxt_q.edges = '0;
        if (master && frame_start) begin
          nxt_q.select_n = 1'b0;
          nxt_q.state = SMS_ST_LEAD;
        end
      end
      SMS_ST_LEAD: begin
        if (tick) begin
          nxt_q.state = SMS_ST_XFER;
        end
      end
      SMS_ST_XFER: begin
        if (tick) begin
          nxt_q.shift_clock = !q_ff.shift_clock;
          nxt_q.edges = q_ff.edges + 4'h1;
          if (q_ff.edges == SMS_EDGE_LAST) begin
            nxt_q.state = SMS_ST_LAG;
          end
        end
      end
      SMS_ST_LAG: begin
        if (tick) begin
          nxt_q.select_n = 1'b1;
          nxt_q.state = SMS_ST_IDLE;
        end
      end
      default: begin
        nxt_q.state = SMS_ST_IDLE;
        nxt_q.select_n = 1'b1;
      end
    endcase

    // Dropping master mode mid-frame abandons the frame cleanly
    if (!master) begin
      nxt_q.state = SMS_ST_IDLE;
      nxt_q.select_n = 1'b1;
      nxt_q.shift_clock = i_cfg.cpol;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_ff <= '{state: SMS_ST_IDLE, shift_clock: 1'b0, select_n: 1'b1, sclk_prev: 1'b0, sel_prev_n: 1'b1,
                tx_sh: SMS_IDLE_FILL, rx_sh: '0, bits: '0, edges: '0, skip: 1'b0, reload: 1'b0,
                rx_valid: 1'b0, rx_data: '0, miso_oe: 1'b0};
    end else if (i_ce) begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_tx_ready = i_ce && (master ? idle : load_now);
  assign o_rx_valid = q_ff.rx_valid;
  assign o_rx_data = q_ff.rx_data;
  assign o_busy = master ? !idle : !i_select_n;
  assign o_shift_clock = q_ff.shift_clock;
  assign o_shift_clock_oe = master;
  assign o_select_n = q_ff.select_n;
  assign o_select_n_oe = master;
  assign o_mosi = sms_out_bit(q_ff.tx_sh, i_cfg.lsb_first_select);
  assign o_mosi_oe = master;
  assign o_miso = sms_out_bit(q_ff.tx_sh, i_cfg.lsb_first_select);
  assign o_miso_oe = q_ff.miso_oe;
endmodule : sms_port
`default_nettype wire

//--- verification/sms_port_checker.sv
/* Pin-level checker of sms_port.
   Assumes config steady within a frame. */
`default_nettype none
module sms_port_checker
  import sms_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire sms_cfg_s i_cfg,
  input wire logic i_select_n,
  input wire logic o_tx_ready,
  input wire logic o_shift_clock,
  input wire logic o_shift_clock_oe,
  input wire logic o_select_n,
  input wire logic o_select_n_oe,
  input wire logic o_mosi,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Edge spacing
  logic sck_d, sel_d, sck_chg, in_frm;
  logic [10:0] cnt_ff, h;
  // First clock edge of a frame ends the lead, which is not a phase
  logic sck_seen_ff;
  assign sck_chg = o_shift_clock != sck_d;
  assign in_frm = i_cfg.master && !o_select_n && !sel_d;
  assign h = {1'b0, i_cfg.half_m1} + 11'h001;
  // Cycles since the last pin change; saturates so idle never wraps
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_d <= 1'b0;
      sel_d <= 1'b1;
      cnt_ff <= 11'h000;
      sck_seen_ff <= 1'b0;
    end else begin
      sck_seen_ff <= !o_select_n && (sck_seen_ff || sck_chg);
      sck_d <= o_shift_clock;
      sel_d <= o_select_n;
      cnt_ff <= (sck_chg || o_select_n != sel_d) ? 11'h001 : cnt_ff + {10'h000, cnt_ff != 11'h7FF};
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_phase_len: assert property (in_frm && sck_chg && sck_seen_ff |-> cnt_ff == h) else $error("phase length");
  a_sel_lead: assert property (in_frm && sck_chg && !sck_seen_ff |-> cnt_ff >= h) else $error("lead");
  a_ready_load: assert property (!i_cfg.master && i_ce && $fell(i_select_n) |-> o_tx_ready) else $error("slave load");
  a_sel_lag: assert property (i_cfg.master && o_select_n && !sel_d |-> cnt_ff >= h) else $error("lag");
  a_ready_busy: assert property (in_frm |-> !o_tx_ready) else $error("ready in frame");
  a_pin_dir: assert property (o_shift_clock_oe == i_cfg.master && o_select_n_oe == i_cfg.master
    && o_mosi_oe == i_cfg.master) else $error("pin direction");
  a_mosi_edge: assert property (in_frm && o_mosi != $past(o_mosi)
    |-> sck_chg && o_shift_clock == (i_cfg.cpol ^ i_cfg.cpha)) else $error("mosi edge");
  a_miso_on: assert property (!i_cfg.master && $fell(i_select_n) |=> o_miso_oe) else $error("miso on");
  a_miso_off: assert property (!i_cfg.master && $rose(i_select_n) |=> !o_miso_oe) else $error("miso off");
  a_miso_hiz: assert property (i_select_n && $past(i_select_n) |-> !o_miso_oe) else $error("miso idle");
endmodule : sms_port_checker
bind sms_port sms_port_checker u_chk (.i_clock, .i_rst_n, .i_ce, .i_cfg, .i_select_n, .o_tx_ready, .o_shift_clock,
  .o_shift_clock_oe, .o_select_n, .o_select_n_oe, .o_mosi, .o_mosi_oe, .o_miso_oe);
`default_nettype wire

//--- verification/sms_slave_model.sv
/* Far-side slave model for the port in master mode.
   Assumes resolved pins; reacts at once to clock edges. */
`default_nettype none
module sms_slave_model
  import sms_pkg::*;
(
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  input wire sms_cfg_s i_cfg,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx,
  output logic o_got
);
  timeunit 1ns;
  timeprecision 1ns;
  int j = 0;
  int k = 0;
  initial begin
    o_miso = 1'b0;
    o_got = 1'b0;
    o_rx = 8'h00;
  end
  function automatic logic bt(input int n);
    bt = i_cfg.lsb_first_select ? i_tx[n & 7] : i_tx[7 - (n & 7)];
  endfunction : bt
  always @(negedge i_sel_n) begin
    j = 0;
    k = 0;
    o_got = 1'b0;
    o_miso = bt(0);
  end
  // Released line inverts so a stale bit never reads as valid
  always @(posedge i_sel_n) o_miso = ~o_miso;
  always @(i_sck) begin
    if (!i_sel_n && ((i_sck != i_cfg.cpol) ^ i_cfg.cpha)) begin
      o_rx[i_cfg.lsb_first_select ? k : 7 - k] = i_mosi;
      k++;
      o_got = k == 8;
    end else if (!i_sel_n) begin
      j++;
      o_miso = bt(i_cfg.cpha ? j - 1 : j);
    end
  end
endmodule : sms_slave_model
`default_nettype wire

//--- verification/spi_master_slave_sequencing_tb.sv
/* Bench of sms_port: slave model as far side, bench as master in slave mode.
   Assumes one 100 MHz clock. */
`default_nettype none
module spi_master_slave_sequencing_tb
  import sms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_tx_valid = 1'b0, tsck = 1'b0, tsel = 1'b1, tmosi = 1'b0;
  sms_cfg_s i_cfg = '0;
  logic [7:0] i_tx_data = 8'h00, ptx = 8'h00, o_rx_data, p_rx;
  logic o_tx_ready, o_rx_valid, o_busy, o_shift_clock, o_shift_clock_oe, o_select_n, o_select_n_oe;
  logic o_mosi, o_mosi_oe, o_miso, o_miso_oe, p_miso, p_got, sck_w, sel_w, mosi_w, miso_w;
  logic [7:0] dq[$], pq[$];
  int failures = 0, checks_done = 0, cyc = 0;
  // ==========
  // Pins and parties
  assign sck_w = o_shift_clock_oe ? o_shift_clock : tsck;
  assign sel_w = o_select_n_oe ? o_select_n : tsel;
  assign mosi_w = o_mosi_oe ? o_mosi : tmosi;
  assign miso_w = o_miso_oe ? o_miso : p_miso;
  sms_port DUT (.i_clock, .i_rst_n, .i_ce, .i_cfg, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid, .o_rx_data,
    .o_busy, .i_shift_clock(sck_w), .o_shift_clock, .o_shift_clock_oe, .i_select_n(sel_w), .o_select_n,
    .o_select_n_oe, .i_mosi(mosi_w), .o_mosi, .o_mosi_oe, .i_miso(miso_w), .o_miso, .o_miso_oe);
  sms_slave_model u_far (.i_sck(sck_w), .i_sel_n(sel_w | ~i_cfg.master), .i_mosi(mosi_w), .i_cfg, .i_tx(ptx),
    .o_miso(p_miso), .o_rx(p_rx), .o_got(p_got));
  initial forever #5 i_clock = ~i_clock;
  task cmp(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp
  task test_done;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge i_clock) if (o_rx_valid === 1'b1) cmp(dq.pop_front(), o_rx_data);
  always @(posedge p_got) cmp(pq.pop_front(), p_rx);
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end
  // ==========
  // Master frames: m is cpol, cpha, lsb_first_select
  task mx(input logic [2:0] m, input logic [9:0] h);
    int n;
    i_cfg <= '{1'b1, m[2], m[1], m[0], h};
    i_tx_data <= 8'($urandom);
    ptx <= 8'($urandom);
    // Idle clock moves to the new polarity first, so no stray edge meets the select fall
    @(posedge i_clock);
    i_tx_valid <= 1'b1;
    @(posedge i_clock);
    dq.push_back(ptx);
    pq.push_back(i_tx_data);
    for (n = 0; o_tx_ready !== 1'b1 && n < 100; n++) @(posedge i_clock);
    i_tx_valid <= 1'b0;
    @(posedge i_clock);
    for (n = 0; o_busy === 1'b1 && n < 20000; n++) @(posedge i_clock);
    if (n == 20000) failures++;
  endtask : mx
  // Bench as external master: six-cycle period, three-cycle lead and lag
  task sx(input logic [2:0] m, input logic v);
    logic [7:0] a, b, c;
    int k, x;
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'h00;
    i_cfg <= '{1'b0, m[2], m[1], m[0], 10'h000};
    i_tx_data <= b;
    i_tx_valid <= v;
    tsck <= m[2];
    dq.push_back(a);
    repeat (2) @(posedge i_clock);
    tsel <= 1'b0;
    tmosi <= m[0] ? a[0] : a[7];
    repeat (3) @(posedge i_clock);
    for (int e = 0; e < 16; e++) begin
      k = e >> 1;
      x = (e + 1) >> 1;
      if (!e[0] ^ m[1]) c[m[0] ? k : 7 - k] = miso_w;
      else if (x < 8) tmosi <= m[0] ? a[x] : a[7 - x];
      tsck <= ~tsck;
      repeat (3) @(posedge i_clock);
    end
    tsel <= 1'b1;
    tmosi <= ~tmosi;
    cmp(v ? b : SMS_IDLE_FILL, c);
    @(posedge i_clock);
  endtask : sx
  initial begin
    void'($urandom(32'h7EDAE852));
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    for (int i = 0; i < 8; i++) mx(3'(i), 10'($urandom_range(3)));
    mx(3'h5, 10'h3FF);
    for (int i = 0; i < 8; i++) sx(3'(i), 1'b1);
    sx(3'h2, 1'b0);
    repeat (5) @(posedge i_clock);
    test_done();
  end
endmodule : spi_master_slave_sequencing_tb
`default_nettype wire
